// >>> supply_fault_supervisor.sv
/*
  Supply fault supervisor: sticky supply and thermal flags, regulator and
  transceiver gating, reset and fail outputs, mode requests and the
  consecutive undervoltage counter.
  Assumes comparator and wake inputs are asynchronous, mode and software
  strobes come from logic on clk, and a separate mode machine acts on the
  one-cycle restart and fail-safe requests.
*/
`timescale 1ns/10ps
module supply_fault_supervisor #(
  parameter int SC_FILTER = supply_fault_pkg::SC_FILTER_CYCLES
) (
  input  wire logic                                 clk,
  input  wire logic                                 rst,
  input  supply_fault_pkg::mode_e                   mode,
  input  wire logic                                 soft_reset,
  input  wire logic                                 battery_supply_uv,
  input  wire logic                                 high_side_supply_uv,
  input  wire logic                                 high_side_supply_ov,
  input  wire logic                                 main_regulator_warn,
  input  wire logic                                 main_regulator_uv,
  input  wire logic                                 main_regulator_ov,
  input  wire logic                                 aux_regulator_uv,
  input  wire logic                                 aux_regulator_ramping,
  input  wire logic                                 can_supply_uv,
  input  wire logic                                 aux_regulator_ot,
  input  wire logic                                 can_ot,
  input  wire logic [supply_fault_pkg::N_LIN-1:0]   lin_ot,
  input  wire logic [supply_fault_pkg::N_HS-1:0]    high_side_ot,
  input  wire logic                                 wake_event,
  input  wire logic                                 pnp_load_sharing,
  input  wire logic                                 pnp_keep_on_under_battery_uv,
  input  wire logic                                 pnp_stop_keep_on,
  input  wire logic                                 configuration_select,
  input  wire logic                                 overvoltage_reset_enable_wr,
  input  wire logic                                 overvoltage_reset_enable_wdata,
  input  wire logic                                 aux_regulator_enable_wr,
  input  wire logic [1:0]                           aux_regulator_enable_wdata,
  input  wire logic                                 high_side_switches_wr,
  input  wire logic [supply_fault_pkg::N_HS-1:0]    high_side_switches_wdata,
  input  wire logic [supply_fault_pkg::N_FLAGS-1:0] flag_clear,
  input  wire logic [supply_fault_pkg::N_HS-1:0]    high_side_flag_clear,
  input  wire logic                                 can_failure_clear,
  input  wire logic [supply_fault_pkg::N_LIN-1:0]   lin_failure_clear,
  input  wire logic                                 can_active,
  output logic [supply_fault_pkg::N_FLAGS-1:0]      flags,
  output logic [supply_fault_pkg::N_HS-1:0]         high_side_overcurrent_overtemp_flags,
  output logic [1:0]                                can_failure_field,
  output logic [1:0]                                lin_channel_one_failure_field,
  output logic [1:0]                                lin_channel_two_failure_field,
  output logic                                      overvoltage_reset_enable,
  output logic [1:0]                                aux_regulator_enable_bits,
  output logic [supply_fault_pkg::N_HS-1:0]         high_side_switches,
  output logic                                      reset_output_n,
  output logic                                      fail_outputs,
  output logic                                      main_regulator_on,
  output logic                                      main_sc_protect_active,
  output logic                                      pnp_regulator_enable,
  output logic [supply_fault_pkg::N_LIN-1:0]        lin_tx_enable,
  output logic [supply_fault_pkg::N_LIN-1:0]        lin_rx_enable,
  output logic                                      can_tx_enable,
  output logic                                      restart_request,
  output logic                                      fail_safe_request,
  output logic [supply_fault_pkg::UV_COUNT_W-1:0]   main_uv_count
);
  import supply_fault_pkg::*;

  // twelve single comparator levels plus the per-channel vectors
  localparam int N_ASYNC = 12 + N_LIN + N_HS;

  logic [N_ASYNC-1:0] async_bus;
  logic [N_ASYNC-1:0] sync_bus;
  logic               bat_uv;
  logic               hs_uv;
  logic               hs_ov;
  logic               m_warn;
  logic               m_uv;
  logic               m_ov;
  logic               aux_uv;
  logic               aux_ramp;
  logic               can_uv;
  logic               aux_ot;
  logic               can_ot_s;
  logic [N_LIN-1:0]   lin_ot_s;
  logic [N_HS-1:0]    hs_ot;
  logic               wake;
  logic               m_uv_prev;
  logic               m_ov_prev;
  logic               uv_event;
  logic               ov_event;
  logic               ov_restart;
  logic               ov_fail_safe;
  logic               sc_trip;
  logic               sc_running;
  logic [SC_TIMER_W-1:0] sc_timer;
  logic               sleeping;
  logic               aux_ot_hit;
  logic               hs_ot_hit;
  logic               can_ot_hit;
  logic [N_LIN-1:0]   lin_ot_hit;
  logic               any_individual_thermal_shutdown_flag;
  logic               fail_hold;
  logic [N_FLAGS-1:0] flag_set;
  logic [N_FLAGS-1:0] flag_busy;
  logic               main_uv_cleared;

  uv_count_if cnt_if ();

  assign async_bus = {high_side_ot, lin_ot, can_ot, aux_regulator_ot, can_supply_uv,
                      aux_regulator_ramping, aux_regulator_uv, main_regulator_ov,
                      main_regulator_uv, main_regulator_warn, high_side_supply_ov,
                      high_side_supply_uv, battery_supply_uv, wake_event};

  level_sync #(.WIDTH(N_ASYNC)) u_sync (
    .clk      (clk),
    .rst      (rst),
    .async_in (async_bus),
    .sync_out (sync_bus)
  );

  assign {hs_ot, lin_ot_s, can_ot_s, aux_ot, can_uv, aux_ramp, aux_uv, m_ov, m_uv, m_warn,
          hs_ov, hs_uv, bat_uv, wake} = sync_bus;

  assign sleeping = (mode == MODE_SLEEP);

  // main events masked in sleep and while the regulator is off
  assign uv_event = m_uv && !m_uv_prev && !sleeping && main_regulator_on;
  // overvoltage watched in init and normal only
  assign ov_event = m_ov && !m_ov_prev && (mode == MODE_INIT || mode == MODE_NORMAL);
  assign ov_restart   = ov_event && overvoltage_reset_enable && configuration_select;
  assign ov_fail_safe = ov_event && overvoltage_reset_enable && !configuration_select;

  always_ff @(posedge clk) begin
    if (rst) begin
      m_uv_prev <= 1'b0;
      m_ov_prev <= 1'b0;
    end else begin
      m_uv_prev <= m_uv;
      m_ov_prev <= m_ov;
    end
  end

  // counter runs in init, normal and stop
  assign cnt_if.event_hit = uv_event;
  assign cnt_if.active    = (mode == MODE_INIT || mode == MODE_NORMAL || mode == MODE_STOP);
  // held in normal while battery is low
  assign cnt_if.hold      = (mode == MODE_NORMAL) && bat_uv;
  assign cnt_if.clear     = (mode == MODE_FAIL_SAFE) || main_uv_cleared || soft_reset;
  assign main_uv_count    = cnt_if.count;

  uv_event_counter u_uv_count (
    .clk (clk),
    .rst (rst),
    .cnt (cnt_if)
  );

  // short-circuit filter; restarted from zero under battery undervoltage
  assign sc_running = m_uv && main_regulator_on && !sleeping && !bat_uv;
  assign sc_trip    = sc_running && sc_timer == SC_TIMER_W'(SC_FILTER - 1);

  always_ff @(posedge clk) begin
    if (rst) begin
      sc_timer <= SC_TIMER_RESET;
    end else if (!sc_running || sc_trip) begin
      sc_timer <= SC_TIMER_RESET;
    end else begin
      sc_timer <= sc_timer + 20'h00001;
    end
  end

  assign main_sc_protect_active = !bat_uv;

  // regulator off until a bus or wake-input wake
  always_ff @(posedge clk) begin
    if (rst) begin
      main_regulator_on <= 1'b1;
    end else if (sc_trip) begin
      main_regulator_on <= 1'b0;
    end else if (wake) begin
      main_regulator_on <= 1'b1;
    end
  end

  // thermal detection only counts for stages that are on
  assign aux_ot_hit = aux_ot && (aux_regulator_enable_bits != AUX_RESET);
  assign hs_ot_hit  = |(hs_ot & high_side_switches);
  assign can_ot_hit = can_ot_s && can_active;
  assign lin_ot_hit = lin_ot_s & ~{N_LIN{hs_uv}};
  assign any_individual_thermal_shutdown_flag   = aux_ot || (|hs_ot) || can_ot_s || (|lin_ot_s);

  // flag set sources
  always_comb begin
    flag_set                  = '0;
    flag_set[FLAG_BATTERY_UV] = bat_uv;
    flag_set[FLAG_HS_UV]      = hs_uv;
    flag_set[FLAG_HS_OV]      = hs_ov;
    flag_set[FLAG_MAIN_WARN]  = m_warn && !sleeping && main_regulator_on;
    flag_set[FLAG_MAIN_UV]    = uv_event;
    flag_set[FLAG_MAIN_UV_FS] = cnt_if.fourth;
    flag_set[FLAG_MAIN_OV]    = ov_event;
    flag_set[FLAG_MAIN_SC]    = sc_trip;
    flag_set[FLAG_FAILURE]    = sc_trip;
    flag_set[FLAG_AUX_UV]     = aux_uv && !aux_ramp && (aux_regulator_enable_bits != AUX_RESET);
    flag_set[FLAG_CAN_UV]     = can_uv;
    flag_set[FLAG_INDIVIDUAL_THERMAL_SHUTDOWN_FLAG]       = aux_ot_hit || hs_ot_hit || can_ot_hit || (|lin_ot_hit);
    flag_set[FLAG_AUX_OT]     = aux_ot_hit;
  end

  // clears refused while the cause persists
  always_comb begin
    flag_busy                  = '0;
    flag_busy[FLAG_BATTERY_UV] = bat_uv;
    flag_busy[FLAG_HS_UV]      = hs_uv;
    flag_busy[FLAG_HS_OV]      = hs_ov;
    flag_busy[FLAG_INDIVIDUAL_THERMAL_SHUTDOWN_FLAG]       = any_individual_thermal_shutdown_flag;
    flag_busy[FLAG_AUX_OT]     = aux_ot;
  end

  for (genvar i = 0; i < N_FLAGS; i++) begin : g_flag
    always_ff @(posedge clk) begin
      if (rst) begin
        flags[i] <= FLAGS_RESET[i];
      end else if (flag_set[i]) begin
        flags[i] <= 1'b1;
      end else if (flag_clear[i] && !flag_busy[i]) begin
        flags[i] <= 1'b0;
      end
    end
  end

  assign main_uv_cleared = flags[FLAG_MAIN_UV] && flag_clear[FLAG_MAIN_UV]
                           && !flag_set[FLAG_MAIN_UV];

  // any hot switch that is on drops all switches and marks all flags
  for (genvar h = 0; h < N_HS; h++) begin : g_hs
    always_ff @(posedge clk) begin
      if (rst) begin
        high_side_overcurrent_overtemp_flags[h] <= 1'b0;
      end else if (hs_ot_hit) begin
        high_side_overcurrent_overtemp_flags[h] <= 1'b1;
      end else if (high_side_flag_clear[h] && !hs_ot[h]) begin
        high_side_overcurrent_overtemp_flags[h] <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      high_side_switches <= HS_RESET;
    end else if (hs_ot_hit) begin
      high_side_switches <= HS_RESET;
    end else if (high_side_switches_wr) begin
      high_side_switches <= high_side_switches_wdata;
    end
  end

  // aux enables cleared, software must re-enable
  always_ff @(posedge clk) begin
    if (rst) begin
      aux_regulator_enable_bits <= AUX_RESET;
    end else if (aux_ot_hit) begin
      aux_regulator_enable_bits <= AUX_RESET;
    end else if (aux_regulator_enable_wr) begin
      aux_regulator_enable_bits <= aux_regulator_enable_wdata;
    end
  end

  // failure fields show 01 on overtemperature
  always_ff @(posedge clk) begin
    if (rst) begin
      can_failure_field <= FAIL_NONE;
    end else if (can_ot_hit) begin
      can_failure_field <= FAIL_OT;
    end else if (can_failure_clear && !can_ot_s) begin
      can_failure_field <= FAIL_NONE;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      lin_channel_one_failure_field <= FAIL_NONE;
      lin_channel_two_failure_field <= FAIL_NONE;
    end else begin
      if (lin_ot_hit[0]) begin
        lin_channel_one_failure_field <= FAIL_OT;
      end else if (lin_failure_clear[0] && !lin_ot_s[0]) begin
        lin_channel_one_failure_field <= FAIL_NONE;
      end
      if (lin_ot_hit[1]) begin
        lin_channel_two_failure_field <= FAIL_OT;
      end else if (lin_failure_clear[1] && !lin_ot_s[1]) begin
        lin_channel_two_failure_field <= FAIL_NONE;
      end
    end
  end

  // enable bit self-clears once the restart is taken
  always_ff @(posedge clk) begin
    if (rst) begin
      overvoltage_reset_enable <= 1'b0;
    end else if (ov_restart) begin
      overvoltage_reset_enable <= 1'b0;
    end else if (overvoltage_reset_enable_wr) begin
      // software writes zero here before stop
      overvoltage_reset_enable <= overvoltage_reset_enable_wdata;
    end
  end

  // restart on undervoltage except the fourth event; or on overvoltage, select one
  always_ff @(posedge clk) begin
    if (rst) begin
      restart_request <= 1'b0;
    end else begin
      restart_request <= (uv_event && !cnt_if.fourth) || ov_restart;
    end
  end

  // fourth event; overvoltage, select zero; short trip
  always_ff @(posedge clk) begin
    if (rst) begin
      fail_safe_request <= 1'b0;
    end else begin
      fail_safe_request <= cnt_if.fourth || ov_fail_safe || sc_trip;
    end
  end

  // fail outputs latch until the next wake outside restart mode
  always_ff @(posedge clk) begin
    if (rst) begin
      fail_hold <= 1'b0;
    end else if (ov_restart || ov_fail_safe || sc_trip) begin
      fail_hold <= 1'b1;
    end else if (wake && mode != MODE_RESTART) begin
      fail_hold <= 1'b0;
    end
  end

  assign fail_outputs = fail_hold;

  // reset output low while main supply is under threshold outside sleep
  always_ff @(posedge clk) begin
    if (rst) begin
      reset_output_n <= 1'b0;
    end else begin
      reset_output_n <= !(m_uv && !sleeping) && main_regulator_on;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      pnp_regulator_enable <= 1'b0;
    end else begin
      pnp_regulator_enable <= !(bat_uv && !pnp_keep_on_under_battery_uv)
                              && !(pnp_load_sharing && mode == MODE_STOP && !pnp_stop_keep_on);
    end
  end

  // LIN off during high-side undervoltage; tx off when hot
  always_ff @(posedge clk) begin
    if (rst) begin
      lin_tx_enable <= '0;
      lin_rx_enable <= '0;
      can_tx_enable <= 1'b0;
    end else begin
      lin_tx_enable <= ~({N_LIN{hs_uv}} | lin_ot_s);
      lin_rx_enable <= ~{N_LIN{hs_uv}};
      can_tx_enable <= !can_ot_s;
    end
  end

endmodule

// >>> supply_fault_pkg.sv
/*
  Shared constants and types of the supply fault supervisor: flag indices,
  mode encoding, counter widths, reset values and filter timing.
  Assumes a single 250 MHz clock domain.
*/
package supply_fault_pkg;

  typedef enum logic [2:0] {
    MODE_INIT      = 3'h0,
    MODE_NORMAL    = 3'h1,
    MODE_STOP      = 3'h2,
    MODE_SLEEP     = 3'h3,
    MODE_RESTART   = 3'h4,
    MODE_FAIL_SAFE = 3'h5
  } mode_e;

  // positions in the sticky flag vector
  localparam int FLAG_BATTERY_UV = 0;
  localparam int FLAG_HS_UV      = 1;
  localparam int FLAG_HS_OV      = 2;
  localparam int FLAG_MAIN_WARN  = 3;
  localparam int FLAG_MAIN_UV    = 4;
  localparam int FLAG_MAIN_UV_FS = 5;
  localparam int FLAG_MAIN_OV    = 6;
  localparam int FLAG_MAIN_SC    = 7;
  localparam int FLAG_FAILURE    = 8;
  localparam int FLAG_AUX_UV     = 9;
  localparam int FLAG_CAN_UV     = 10;
  localparam int FLAG_INDIVIDUAL_THERMAL_SHUTDOWN_FLAG       = 11;
  localparam int FLAG_AUX_OT     = 12;
  localparam int N_FLAGS         = 13;

  localparam int N_HS  = 4;
  localparam int N_LIN = 2;

  localparam logic [N_FLAGS-1:0] FLAGS_RESET = 13'h0000;
  localparam logic [N_HS-1:0]    HS_RESET    = 4'h0;
  localparam logic [1:0]         AUX_RESET   = 2'h0;
  localparam logic [1:0]         FAIL_NONE   = 2'h0;
  localparam logic [1:0]         FAIL_OT     = 2'h1;

  localparam int          UV_COUNT_W     = 3;
  localparam logic [2:0]  UV_COUNT_RESET = 3'h0;
  localparam logic [2:0]  UV_COUNT_LIMIT = 3'h4;

  localparam int CLK_PERIOD_PS      = 4000;
  localparam int SC_FILTER_US       = 4000;
  // filter in nanoseconds over the clock period in nanoseconds, kept inside int range
  localparam int SC_FILTER_CYCLES   = SC_FILTER_US * 1000 / (CLK_PERIOD_PS / 1000);
  localparam int SC_TIMER_W         = 20;
  localparam logic [19:0] SC_TIMER_RESET = 20'h00000;

  localparam int SYNC_STAGES = 2;

endpackage

// >>> uv_count_if.sv
/*
  Carrier between the supervisor and its undervoltage event counter.
  Assumes both ends share one clock.
*/
`timescale 1ns/10ps
interface uv_count_if;
  import supply_fault_pkg::*;
  logic                  event_hit;
  logic                  hold;
  logic                  active;
  logic                  clear;
  logic [UV_COUNT_W-1:0] count;
  logic                  fourth;

  modport counter (input event_hit, hold, active, clear, output count, fourth);
  modport user    (output event_hit, hold, active, clear, input count, fourth);
endinterface

// >>> level_sync.sv
/*
  Two flip-flop synchroniser for a vector of asynchronous comparator levels.
  Assumes each bit is an independent level; no bus coherence is kept.
*/
`timescale 1ns/10ps
module level_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             clk,
  input  wire logic             rst,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] meta;

  always_ff @(posedge clk) begin
    if (rst) begin
      meta     <= '0;
      sync_out <= '0;
    end else begin
      meta     <= async_in;
      sync_out <= meta;
    end
  end
endmodule

// >>> uv_event_counter.sv
/*
  Counter of consecutive main regulator undervoltage events.
  Assumes event_hit is a one-cycle pulse from the supervisor.
*/
`timescale 1ns/10ps
module uv_event_counter (
  input  wire logic clk,
  input  wire logic rst,
  uv_count_if.counter cnt
);
  import supply_fault_pkg::*;

  logic [UV_COUNT_W-1:0] count;

  assign cnt.count = count;

  always_ff @(posedge clk) begin
    if (rst) begin
      count <= UV_COUNT_RESET;
    end else if (cnt.clear) begin
      count <= UV_COUNT_RESET;
    end else if (cnt.event_hit && cnt.active && !cnt.hold && count != UV_COUNT_LIMIT) begin
      count <= count + 3'h1;
    end
  end

  // fourth event, same cycle
  // combinational so the supervisor can withhold the restart of that very event
  assign cnt.fourth = cnt.event_hit && cnt.active && !cnt.hold && !cnt.clear
                      && count == UV_COUNT_LIMIT - 3'h1;
endmodule

// >>> supply_fault_monitor.sv
/* assertions on the supervisor ports
   assumes one clock domain, bound into supply_fault_supervisor */
`timescale 1ns/10ps
module supply_fault_monitor
  import supply_fault_pkg::*;
(
  input wire logic        clk,
  input wire logic        rst,
  input wire logic        battery_supply_uv,
  input wire logic        soft_reset,
  input wire logic        pnp_keep_on_under_battery_uv,
  input wire logic [12:0] flags,
  input wire logic        main_sc_protect_active,
  input wire logic        pnp_regulator_enable,
  input wire logic        reset_output_n,
  input wire logic        restart_request,
  input wire logic        fail_safe_request,
  input wire logic [2:0]  main_uv_count,
  input wire logic        fail_outputs,
  input wire logic        overvoltage_reset_enable,
  input wire logic        main_regulator_on
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  // two sync stages plus the flag register
  a_batt_uv_flag: assert property ($rose(battery_supply_uv) |-> ##[2:3] flags[0])
    else $error("battery uv flag late");
  a_sc_paused: assert property (battery_supply_uv [*3] |-> !main_sc_protect_active)
    else $error("short protection active in low battery");
  a_pnp_gated: assert property (
    (battery_supply_uv && !pnp_keep_on_under_battery_uv) [*4] |-> !pnp_regulator_enable)
    else $error("pnp left on in low battery");
  a_uv_reset: assert property (
    $rose(flags[4]) |-> !reset_output_n && (restart_request || fail_safe_request))
    else $error("main uv without reset");
  a_fourth_fs: assert property (
    $rose(flags[5]) |-> fail_safe_request && main_uv_count == 3'h4)
    else $error("fourth event not fail-safe");
  a_soft_clear: assert property (soft_reset |=> main_uv_count == 3'h0)
    else $error("count kept after soft reset");
  a_sc_off: assert property (
    $fell(main_regulator_on) |-> fail_outputs && flags[7] && flags[8])
    else $error("regulator off without fault flags");
  a_ov_restart: assert property (
    $rose(fail_outputs) && restart_request |-> !overvoltage_reset_enable)
    else $error("ov restart kept enable bit");
  cover property (fail_safe_request && main_uv_count == 3'h4);
  cover property ($fell(main_regulator_on));
  cover property ($rose(fail_outputs) && restart_request);
endmodule

bind supply_fault_supervisor supply_fault_monitor u_supply_fault_monitor (.*);

// >>> sf_host.sv
/* microcontroller model: clears flags and writes the ov reset bit
   assumes go inputs last one cycle, launched at the falling edge */
`timescale 1ns/10ps
module sf_host (
  input  wire logic        clk,
  input  wire logic        clear_go,
  input  wire logic        ov_go,
  input  wire logic        stop_go,
  input  wire logic [12:0] flags,
  output logic      [12:0] flag_clear,
  output logic             overvoltage_reset_enable_wr,
  output logic             overvoltage_reset_enable_wdata
);
  logic [2:0] req;
  always @(posedge clk) req <= {clear_go, ov_go, stop_go};
  // enable bit written 0 before stop
  always @(negedge clk) begin
    flag_clear <= req[2] ? flags : 13'h0000;
    overvoltage_reset_enable_wr <= req[1] | req[0];
    overvoltage_reset_enable_wdata <= req[1];
  end
endmodule

// >>> tb_top.sv
/* self-checking bench of the supply fault supervisor
   assumes sf_host as the software side, short filter of 20 cycles */
`timescale 1ns/10ps
module tb_top;
  import supply_fault_pkg::*;
  logic clk = 0, rst = 1, clear_go = 0, ov_go = 0, stop_go = 0;
  mode_e mode = MODE_NORMAL;
  logic soft_reset, battery_supply_uv, high_side_supply_uv, high_side_supply_ov;
  logic main_regulator_warn, main_regulator_uv, main_regulator_ov, aux_regulator_uv;
  logic aux_regulator_ramping, can_supply_uv, aux_regulator_ot, can_ot, wake_event;
  logic pnp_load_sharing, pnp_keep_on_under_battery_uv, pnp_stop_keep_on;
  logic configuration_select, aux_regulator_enable_wr, high_side_switches_wr;
  logic can_failure_clear, can_active, overvoltage_reset_enable_wr;
  logic overvoltage_reset_enable_wdata, overvoltage_reset_enable, reset_output_n;
  logic fail_outputs, main_regulator_on, main_sc_protect_active, pnp_regulator_enable;
  logic can_tx_enable, restart_request, fail_safe_request;
  logic [1:0] lin_ot, aux_regulator_enable_wdata, lin_failure_clear, can_failure_field;
  logic [1:0] lin_channel_one_failure_field, lin_channel_two_failure_field;
  logic [1:0] aux_regulator_enable_bits, lin_tx_enable, lin_rx_enable;
  logic [3:0] high_side_ot, high_side_switches_wdata, high_side_flag_clear;
  logic [3:0] high_side_switches, high_side_overcurrent_overtemp_flags;
  logic [12:0] flag_clear, flags;
  logic [2:0] main_uv_count;
  logic [3:0] q[$];
  logic [3:0] e;
  int err_total = 0, total_checks = 0, seed = 79139, i;
  always #2 clk = ~clk;
  supply_fault_supervisor #(.SC_FILTER(20)) u_supply_fault_supervisor (.*);
  sf_host u_sf_host (.*);
  task automatic step(int n); repeat (n) @(negedge clk); endtask
  task automatic chk(logic [19:0] got, logic [19:0] exp);
    total_checks++;
    if (got !== exp) begin
      err_total++;
      $display("unexpected at %0t: got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic end_sim;
    if (err_total == 0 && total_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic clr; clear_go = 1; step(1); clear_go = 0; step(3); endtask
  task automatic ev(int n); main_regulator_uv = 1; step(n); main_regulator_uv = 0; step(8); endtask
  // each request pulse carries {fail-safe, count}; read mid-cycle while it stands
  always @(negedge clk) if ((restart_request || fail_safe_request) && q.size() > 0) begin
    e = q.pop_front();
    chk({fail_safe_request, main_uv_count}, e);
  end
  initial begin
    {soft_reset, battery_supply_uv, high_side_supply_uv, high_side_supply_ov,
     main_regulator_warn, main_regulator_uv, main_regulator_ov, aux_regulator_uv,
     aux_regulator_ramping, can_supply_uv, aux_regulator_ot, can_ot, lin_ot, high_side_ot,
     wake_event, pnp_load_sharing, pnp_keep_on_under_battery_uv, pnp_stop_keep_on,
     configuration_select, aux_regulator_enable_wr, aux_regulator_enable_wdata,
     high_side_switches_wr, high_side_switches_wdata, high_side_flag_clear,
     can_failure_clear, lin_failure_clear, can_active} = '0;
    step(2); rst = 0; step(1);
    chk({reset_output_n, fail_outputs, flags}, 15'h4000);
    battery_supply_uv = 1; step(5);
    chk({flags, pnp_regulator_enable, main_sc_protect_active},
        15'h0004);
    pnp_keep_on_under_battery_uv = 1; step(2);
    chk(pnp_regulator_enable, 1);
    battery_supply_uv = 0; pnp_keep_on_under_battery_uv = 0; step(5); clr();
    chk({flags, pnp_regulator_enable, main_sc_protect_active}, 15'h0003);
    high_side_supply_uv = 1; high_side_supply_ov = 1; step(5); clr();
    chk({flags, lin_tx_enable, lin_rx_enable}, 17'h00060);
    high_side_supply_uv = 0; high_side_supply_ov = 0; main_regulator_warn = 1; step(5); clr();
    chk({flags, lin_rx_enable}, 15'h0023);
    mode = MODE_SLEEP; main_regulator_warn = 0; step(4); clr();
    main_regulator_warn = 1; ev(6);
    chk(flags, 0);
    mode = MODE_NORMAL; main_regulator_warn = 0;
    for (i = 1; i <= 4; i++) begin
      q.push_back({i == 4, 3'(i)}); ev(6);
    end
    chk(flags[FLAG_MAIN_UV_FS], 1);
    clr(); chk(main_uv_count, 0);
    q.push_back(4'h1); ev(6);
    soft_reset = 1; step(1); soft_reset = 0; step(1);
    chk(main_uv_count, 0);
    battery_supply_uv = 1; step(4); q.push_back(4'h0); ev(6);
    battery_supply_uv = 0; step(4); q.push_back(4'h1); main_regulator_uv = 1;
    for (i = 0; i < 60 && main_regulator_on !== 1'b0; i++) step(1);
    if (i == 60) begin err_total++; end_sim(); end
    chk({main_regulator_on, fail_outputs, flags[FLAG_MAIN_SC],
         flags[FLAG_FAILURE]}, 7);
    main_regulator_uv = 0; wake_event = 1; step(4); wake_event = 0; step(2);
    chk({main_regulator_on, fail_outputs}, 2);
    configuration_select = 1; ov_go = 1; step(1); ov_go = 0; main_regulator_ov = 1; step(6);
    chk({flags[FLAG_MAIN_OV], fail_outputs, overvoltage_reset_enable}, 6);
    main_regulator_ov = 0; wake_event = 1; step(4); wake_event = 0; configuration_select = 0;
    ov_go = 1; step(1); ov_go = 0; main_regulator_ov = 1; step(6);
    chk({fail_outputs, overvoltage_reset_enable}, 3);
    stop_go = 1; step(1); stop_go = 0; step(2); main_regulator_ov = 0;
    chk(overvoltage_reset_enable, 0);
    high_side_switches_wr = 1; high_side_switches_wdata = 4'hf; aux_regulator_enable_wr = 1;
    aux_regulator_enable_wdata = 2'h3; step(1); high_side_switches_wr = 0;
    aux_regulator_enable_wr = 0; can_active = 1; aux_regulator_uv = 1; can_supply_uv = 1;
    step(4); high_side_ot = 4'h4; can_ot = 1; lin_ot = 2'h1; aux_regulator_ot = 1; step(5);
    chk({high_side_switches, high_side_overcurrent_overtemp_flags, can_tx_enable,
         can_failure_field, lin_channel_one_failure_field,
         lin_tx_enable}, 15'h0796);
    chk({aux_regulator_enable_bits, flags[12:9]}, 6'h0f);
    high_side_ot = 0; can_ot = 0; lin_ot = 0; step(5);
    chk({can_tx_enable, lin_tx_enable}, 3'h7);
    chk(16'(q.size()), 0);
    repeat (300) begin
      {battery_supply_uv, high_side_supply_uv, high_side_supply_ov, main_regulator_warn,
       main_regulator_uv, main_regulator_ov, aux_regulator_uv, aux_regulator_ramping,
       can_supply_uv, aux_regulator_ot, can_ot, lin_ot, high_side_ot, wake_event,
       pnp_load_sharing, pnp_keep_on_under_battery_uv, pnp_stop_keep_on, configuration_select,
       aux_regulator_enable_wr, aux_regulator_enable_wdata, high_side_switches_wr,
       high_side_switches_wdata, high_side_flag_clear, can_failure_clear, lin_failure_clear,
       can_active, clear_go} = 39'({$random(seed), $random(seed)});
      mode = mode_e'($unsigned($random(seed)) % 6);
      step(1);
    end
    end_sim();
  end
endmodule
